// ---- hw/ca_pkg.sv ----
// Shared constants and types for the counter array capture/compare block.
package ca_pkg;

    // Special function register addresses.
    localparam logic [7:0] CA_RUN_FLAGS_ADDR = 8'hd8;
    localparam logic [7:0] CA_MODE_CTRL_ADDR = 8'hd9;
    localparam logic [7:0] CA_MODULE_MODE_BASE = 8'hda;
    localparam logic [7:0] CA_CNT_LO_ADDR = 8'he9;
    localparam logic [7:0] CA_CNT_HI_ADDR = 8'hf9;
    localparam logic [7:0] CA_CMP_LO_BASE = 8'hea;
    localparam logic [7:0] CA_CMP_HI_BASE = 8'hfa;

    // Field positions in the counter mode control register.
    localparam int CA_IDLE_STOP_POS = 7;
    localparam int CA_WDOG_EN_POS = 6;
    localparam int CA_SRC_HI_POS = 2;
    localparam int CA_SRC_LO_POS = 1;
    localparam int CA_OVF_IRQ_EN_POS = 0;

    // Field positions in the counter run and flags register.
    localparam int CA_OVF_FLAG_POS = 7;
    localparam int CA_RUN_POS = 6;

    // Writable bits and reset values.
    localparam logic [7:0] CA_MODE_CTRL_MASK = 8'hc7;
    localparam logic [7:0] CA_MODE_RESET = 8'h00;
    localparam logic [7:0] CA_MODULE_MODE_MASK = 8'h7f;
    localparam logic [7:0] CA_BYTE_RESET = 8'h00;
    localparam logic CA_PIN_RESET = 1'b1;

    // Count source encodings.
    localparam logic [1:0] CA_SRC_OSC_SLOW = 2'h0;
    localparam logic [1:0] CA_SRC_OSC_FAST = 2'h1;
    localparam logic [1:0] CA_SRC_T0_OVF = 2'h2;
    localparam logic [1:0] CA_SRC_EXT_PIN = 2'h3;

    // Oscillator divide ratios for each oscillator source and core timing mode.
    localparam logic [3:0] CA_DIV_SLOW_12T = 4'hc;
    localparam logic [3:0] CA_DIV_SLOW_6T = 4'h6;
    localparam logic [3:0] CA_DIV_FAST_12T = 4'h4;
    localparam logic [3:0] CA_DIV_FAST_6T = 4'h2;

    localparam logic [15:0] CA_CNT_MAX = 16'hffff;
    localparam logic [7:0] CA_LO_ZERO = 8'h00;

    typedef struct packed {
        logic rsvd;
        logic cmp_en;
        logic rise_cap;
        logic fall_cap;
        logic match;
        logic toggle;
        logic pwm;
        logic irq_en;
    } ca_mode_t;

    typedef struct packed {
        logic [7:0] addr;
        logic wr;
        logic [7:0] wdata;
    } ca_sfr_req_t;

endpackage : ca_pkg

// ---- hw/ca_counter_array.sv ----
// Counter array time base with capture/compare, PWM and watchdog modules.
`timescale 1ns/1ps

module ca_counter_array #(
    parameter int NUM_MOD = 5,
    parameter int WDOG_MOD = 4
) (
    input wire logic sys_clk,
    input wire logic srst,
    input wire ca_pkg::ca_sfr_req_t sfr_req,
    output logic [7:0] sfr_rdata,
    output logic sfr_hit,
    input wire logic cpu_idle,
    input wire logic clock_6t,
    input wire logic t0_overflow,
    input wire logic ext_count_input,
    input wire logic [NUM_MOD-1:0] module_pin_in,
    output logic [NUM_MOD-1:0] module_pin,
    output logic irq_req,
    output logic wdog_reset
);

    generate
        if (NUM_MOD < 1 || NUM_MOD > 5 || WDOG_MOD >= NUM_MOD) begin : g_bad
            $error("ca_counter_array: module count out of range");
        end
    endgenerate

    // True when addr falls in a per-module register group starting at base.
    function automatic logic in_group(input logic [7:0] addr,
                                      input logic [7:0] base);
        in_group = (addr >= base) && (addr - base < 8'(NUM_MOD));
    endfunction : in_group

    localparam int IW = (NUM_MOD > 1) ? $clog2(NUM_MOD) : 1;

    // Control registers.
    logic [7:0] mode_ctrl;
    logic run_bit;
    logic ovf_flag;
    logic [NUM_MOD-1:0] mod_flag;
    logic [15:0] count;
    ca_pkg::ca_mode_t mod_mode [NUM_MOD];
    logic [7:0] cmp_lo [NUM_MOD];
    logic [7:0] cmp_hi [NUM_MOD];

    // Synchronisers and edge history for pins.
    logic [NUM_MOD-1:0] pin_sync1;
    logic [NUM_MOD-1:0] pin_sync2;
    logic [NUM_MOD-1:0] pin_prev;
    logic ext_sync1;
    logic ext_sync2;
    logic ext_prev;

    logic [3:0] div_cnt;
    logic adv_q;

    // Register bus decode.
    wire wr = sfr_req.wr;
    wire [7:0] wdata = sfr_req.wdata;
    wire [7:0] addr = sfr_req.addr;
    wire hit_flags = addr == ca_pkg::CA_RUN_FLAGS_ADDR;
    wire hit_ctrl = addr == ca_pkg::CA_MODE_CTRL_ADDR;
    wire hit_cnt_lo = addr == ca_pkg::CA_CNT_LO_ADDR;
    wire hit_cnt_hi = addr == ca_pkg::CA_CNT_HI_ADDR;
    wire hit_mode = in_group(addr, ca_pkg::CA_MODULE_MODE_BASE);
    wire hit_clo = in_group(addr, ca_pkg::CA_CMP_LO_BASE);
    wire hit_chi = in_group(addr, ca_pkg::CA_CMP_HI_BASE);
    wire [7:0] idx_mode = addr - ca_pkg::CA_MODULE_MODE_BASE;
    wire [7:0] idx_clo = addr - ca_pkg::CA_CMP_LO_BASE;
    wire [7:0] idx_chi = addr - ca_pkg::CA_CMP_HI_BASE;

    // Counter mode control fields.
    wire idle_stop_bit = mode_ctrl[ca_pkg::CA_IDLE_STOP_POS];
    wire wdog_enable_bit = mode_ctrl[ca_pkg::CA_WDOG_EN_POS];
    wire count_source_sel_hi = mode_ctrl[ca_pkg::CA_SRC_HI_POS];
    wire count_source_sel_lo = mode_ctrl[ca_pkg::CA_SRC_LO_POS];
    wire overflow_irq_enable = mode_ctrl[ca_pkg::CA_OVF_IRQ_EN_POS];
    wire [1:0] src_sel = {count_source_sel_hi, count_source_sel_lo};

    // Count source selection; the oscillator is the core clock.
    wire [3:0] div_slow = clock_6t ? ca_pkg::CA_DIV_SLOW_6T
                                   : ca_pkg::CA_DIV_SLOW_12T;
    wire [3:0] div_fast = clock_6t ? ca_pkg::CA_DIV_FAST_6T
                                   : ca_pkg::CA_DIV_FAST_12T;
    wire [3:0] div_lim = (src_sel == ca_pkg::CA_SRC_OSC_SLOW) ? div_slow
                                                              : div_fast;
    wire div_tick = div_cnt >= div_lim - 4'h1;
    wire ext_fall = ext_prev & ~ext_sync2;
    wire src_tick = (src_sel == ca_pkg::CA_SRC_OSC_SLOW) ? div_tick :
                    (src_sel == ca_pkg::CA_SRC_OSC_FAST) ? div_tick :
                    (src_sel == ca_pkg::CA_SRC_T0_OVF) ? t0_overflow :
                    ext_fall;

    // The counter halts when stopped or when idle with the idle-stop bit.
    wire run_go = run_bit & ~(idle_stop_bit & cpu_idle);
    wire adv = run_go & src_tick;
    wire ovf_set = adv & (count == ca_pkg::CA_CNT_MAX);

    logic [15:0] next_count;
    always_comb begin
        next_count = count;
        if (adv) begin
            next_count = count + 16'h0001;
        end
        if (wr && hit_cnt_lo) begin
            next_count[7:0] = wdata;
        end
        if (wr && hit_cnt_hi) begin
            next_count[15:8] = wdata;
        end
    end

    // Per-module logic.
    logic [NUM_MOD-1:0] match_evt;
    logic [NUM_MOD-1:0] cap_evt;
    logic [NUM_MOD-1:0] next_pin;
    logic [NUM_MOD-1:0] next_flag;
    logic [NUM_MOD-1:0] mod_irq;
    ca_pkg::ca_mode_t next_mode [NUM_MOD];
    logic [7:0] next_lo [NUM_MOD];
    logic [7:0] next_hi [NUM_MOD];

    // Compare and the PWM reload act on the counter value one cycle after it advances.
    wire lo_wrapped = adv_q & (count[7:0] == ca_pkg::CA_LO_ZERO);

    genvar gi;
    generate
        for (gi = 0; gi < NUM_MOD; gi++) begin : g_mod
            ca_pkg::ca_mode_t m;
            wire pin_rise;
            wire pin_fall;
            wire pwm_mode;
            wire cmp_mode;
            wire sel_mode;
            wire sel_lo;
            wire sel_hi;
            assign m = mod_mode[gi];
            assign pin_rise = ~pin_prev[gi] & pin_sync2[gi];
            assign pin_fall = pin_prev[gi] & ~pin_sync2[gi];
            assign pwm_mode = m.pwm & m.cmp_en;
            assign cmp_mode = m.cmp_en & m.match & ~m.pwm;
            assign sel_mode = wr & hit_mode & (idx_mode == 8'(gi));
            assign sel_lo = wr & hit_clo & (idx_clo == 8'(gi));
            assign sel_hi = wr & hit_chi & (idx_chi == 8'(gi));

            assign cap_evt[gi] = (m.rise_cap & pin_rise) |
                                 (m.fall_cap & pin_fall);
            assign match_evt[gi] = adv_q & cmp_mode &
                                   (count == {cmp_hi[gi], cmp_lo[gi]});

            // Capture wins over a software write to the same byte.
            assign next_lo[gi] = cap_evt[gi] ? count[7:0] :
                                 sel_lo ? wdata :
                                 (pwm_mode & lo_wrapped) ? cmp_hi[gi] :
                                 cmp_lo[gi];
            assign next_hi[gi] = cap_evt[gi] ? count[15:8] :
                                 sel_hi ? wdata : cmp_hi[gi];
            assign next_mode[gi] = sel_mode
                ? ca_pkg::ca_mode_t'(wdata & ca_pkg::CA_MODULE_MODE_MASK)
                : m;

            // A hardware event in the clearing cycle keeps the flag set.
            assign next_flag[gi] = match_evt[gi] | cap_evt[gi] |
                (wr && hit_flags ? wdata[gi] : mod_flag[gi]);
            assign mod_irq[gi] = mod_flag[gi] & m.irq_en;

            assign next_pin[gi] =
                pwm_mode ? (count[7:0] >= cmp_lo[gi]) :
                (match_evt[gi] & m.toggle) ? ~module_pin[gi] :
                module_pin[gi];
        end
    endgenerate

    // Watchdog reset is internal only; no external pin is driven.
    wire wdog_active = wdog_enable_bit & mod_mode[WDOG_MOD].cmp_en &
                       mod_mode[WDOG_MOD].match;
    wire next_wdog = wdog_active & match_evt[WDOG_MOD];

    // Software may set or clear the overflow flag; rollover sets it.
    wire next_ovf = ovf_set |
        (wr && hit_flags ? wdata[ca_pkg::CA_OVF_FLAG_POS] : ovf_flag);

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            // Module pins idle high, so their history starts high and no rising
            // edge is seen right after reset; the count pin history starts low.
            pin_sync1 <= {NUM_MOD{ca_pkg::CA_PIN_RESET}};
            pin_sync2 <= {NUM_MOD{ca_pkg::CA_PIN_RESET}};
            pin_prev <= {NUM_MOD{ca_pkg::CA_PIN_RESET}};
            ext_sync1 <= 1'b0;
            ext_sync2 <= 1'b0;
            ext_prev <= 1'b0;
        end else begin
            pin_sync1 <= module_pin_in;
            pin_sync2 <= pin_sync1;
            pin_prev <= pin_sync2;
            ext_sync1 <= ext_count_input;
            ext_sync2 <= ext_sync1;
            ext_prev <= ext_sync2;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            div_cnt <= 4'h0;
        end else if (!run_go || div_tick) begin
            div_cnt <= 4'h0;
        end else begin
            div_cnt <= div_cnt + 4'h1;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            mode_ctrl <= ca_pkg::CA_MODE_RESET;
            run_bit <= 1'b0;
            ovf_flag <= 1'b0;
            count <= 16'h0000;
            adv_q <= 1'b0;
            wdog_reset <= 1'b0;
        end else begin
            if (wr && hit_ctrl) begin
                mode_ctrl <= wdata & ca_pkg::CA_MODE_CTRL_MASK;
            end
            if (wr && hit_flags) begin
                run_bit <= wdata[ca_pkg::CA_RUN_POS];
            end
            ovf_flag <= next_ovf;
            count <= next_count;
            adv_q <= adv;
            wdog_reset <= next_wdog;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            mod_flag <= '0;
            module_pin <= {NUM_MOD{ca_pkg::CA_PIN_RESET}};
            for (int i = 0; i < NUM_MOD; i++) begin
                mod_mode[i] <= ca_pkg::ca_mode_t'(ca_pkg::CA_BYTE_RESET);
                cmp_lo[i] <= ca_pkg::CA_BYTE_RESET;
                cmp_hi[i] <= ca_pkg::CA_BYTE_RESET;
            end
        end else begin
            mod_flag <= next_flag;
            module_pin <= next_pin;
            for (int i = 0; i < NUM_MOD; i++) begin
                mod_mode[i] <= next_mode[i];
                cmp_lo[i] <= next_lo[i];
                cmp_hi[i] <= next_hi[i];
            end
        end
    end

    assign irq_req = (ovf_flag & overflow_irq_enable) | (|mod_irq);

    // Read data is combinational from registers, valid in the access cycle.
    logic [7:0] flags_rd;
    always_comb begin
        flags_rd = 8'h00;
        flags_rd[ca_pkg::CA_OVF_FLAG_POS] = ovf_flag;
        flags_rd[ca_pkg::CA_RUN_POS] = run_bit;
        flags_rd[NUM_MOD-1:0] = mod_flag;
    end

    wire [IW-1:0] rd_mode = idx_mode[IW-1:0];
    wire [IW-1:0] rd_lo = idx_clo[IW-1:0];
    wire [IW-1:0] rd_hi = idx_chi[IW-1:0];

    assign sfr_hit = hit_flags | hit_ctrl | hit_cnt_lo | hit_cnt_hi |
                     hit_mode | hit_clo | hit_chi;
    assign sfr_rdata = hit_flags ? flags_rd :
                       hit_ctrl ? mode_ctrl :
                       hit_cnt_lo ? count[7:0] :
                       hit_cnt_hi ? count[15:8] :
                       hit_mode ? 8'(mod_mode[rd_mode]) :
                       hit_clo ? cmp_lo[rd_lo] :
                       hit_chi ? cmp_hi[rd_hi] :
                       8'h00;

endmodule : ca_counter_array

// ---- tb/ca_pin_model.sv ----
// Model of the pins around the block: module inputs and the count pin.
`timescale 1ns/1ps
module ca_pin_model (
    input wire logic sys_clk,
    input wire logic [4:0] pin_level,
    input wire logic [7:0] ext_pulses,
    input wire logic ext_go,
    output logic ext_count_input,
    output logic [4:0] module_pin_in
);
    logic [10:0] left = 11'h000;
    // Each pulse is four cycles low then four high, slow enough for the
    // two-flop synchroniser; the pin idles high between bursts.
    assign ext_count_input = (left == 11'h000) || !left[2];
    assign module_pin_in = pin_level;
    always @(posedge sys_clk) begin
        if (ext_go) begin
            left <= {ext_pulses, 3'h0};
        end else if (left != 11'h000) begin
            left <= left - 11'h001;
        end
    end
endmodule : ca_pin_model

// ---- tb/ca_counter_array_checker.sv ----
// Port-level assertions for the counter array block.
`timescale 1ns/1ps
module ca_counter_array_checker #(
    parameter int NUM_MOD = 5,
    parameter int WDOG_MOD = 4
) (
    input wire logic sys_clk,
    input wire logic srst,
    input wire ca_pkg::ca_sfr_req_t sfr_req,
    input wire logic [7:0] sfr_rdata,
    input wire logic sfr_hit,
    input wire logic cpu_idle,
    input wire logic clock_6t,
    input wire logic t0_overflow,
    input wire logic ext_count_input,
    input wire logic [NUM_MOD-1:0] module_pin_in,
    input wire logic [NUM_MOD-1:0] module_pin,
    input wire logic irq_req,
    input wire logic wdog_reset
);
    logic run_q, idle_q, wdog_q, ecf_q;
    wire logic [7:0] a = sfr_req.addr;
    wire logic rd_run = !sfr_req.wr && a == ca_pkg::CA_RUN_FLAGS_ADDR;
    wire logic rd_cnt = !sfr_req.wr && a == ca_pkg::CA_CNT_LO_ADDR;
    wire logic wr_run = sfr_req.wr && a == ca_pkg::CA_RUN_FLAGS_ADDR;
    wire logic wr_mode = sfr_req.wr && a == ca_pkg::CA_MODE_CTRL_ADDR;
    // Shadow copies of the control bits, updated as the block takes writes.
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            {run_q, idle_q, wdog_q, ecf_q} <= 4'h0;
        end else if (wr_run) begin
            run_q <= sfr_req.wdata[6];
        end else if (wr_mode) begin
            {idle_q, wdog_q, ecf_q} <= {sfr_req.wdata[7:6], sfr_req.wdata[0]};
        end
    end
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (srst);
    property p_run_wr;
        wr_run ##1 rd_run |-> sfr_rdata[6] == $past(sfr_req.wdata[6]);
    endproperty
    a_run_wr: assert property (p_run_wr)
        else $error("run bit write not taken");
    property p_ovf_keep;
        rd_run && sfr_rdata[7] ##1 rd_run |-> sfr_rdata[7];
    endproperty
    a_ovf_keep: assert property (p_ovf_keep)
        else $error("overflow flag cleared by hardware");
    property p_flag_keep;
        rd_run ##1 rd_run |-> (sfr_rdata[4:0] & $past(sfr_rdata[4:0]))
            == $past(sfr_rdata[4:0]);
    endproperty
    a_flag_keep: assert property (p_flag_keep)
        else $error("module flag cleared by hardware");
    property p_run_hold;
        rd_cnt && !run_q ##1 rd_cnt |-> $stable(sfr_rdata);
    endproperty
    a_run_hold: assert property (p_run_hold)
        else $error("counter moved while stopped");
    property p_idle_hold;
        rd_cnt && idle_q && cpu_idle && $past(cpu_idle) ##1 rd_cnt
            |-> $stable(sfr_rdata);
    endproperty
    a_idle_hold: assert property (p_idle_hold)
        else $error("counter moved in idle with stop set");
    property p_irq_ovf;
        rd_run && sfr_rdata[7] && ecf_q |-> irq_req;
    endproperty
    a_irq_ovf: assert property (p_irq_ovf)
        else $error("overflow interrupt missing");
    // The reset pulse follows the match one cycle later, so the enable is
    // the one that stood in the cycle before.
    property p_wdog_gate;
        wdog_reset |-> $past(wdog_q);
    endproperty
    a_wdog_gate: assert property (p_wdog_gate)
        else $error("watchdog reset while disabled");
    property p_wdog_pulse;
        wdog_reset |=> !wdog_reset;
    endproperty
    a_wdog_pulse: assert property (p_wdog_pulse)
        else $error("watchdog reset longer than one cycle");
endmodule : ca_counter_array_checker
bind ca_counter_array ca_counter_array_checker #(.NUM_MOD(NUM_MOD),
    .WDOG_MOD(WDOG_MOD)) chk_u (.sys_clk, .srst, .sfr_req, .sfr_rdata,
    .sfr_hit, .cpu_idle, .clock_6t, .t0_overflow, .ext_count_input,
    .module_pin_in, .module_pin, .irq_req, .wdog_reset);

// ---- tb/ca_counter_array_tb.sv ----
// Self-checking testbench for the counter array block.
`timescale 1ns/1ps
module ca_counter_array_tb;
    localparam logic [7:0] RUN = ca_pkg::CA_RUN_FLAGS_ADDR;
    localparam logic [7:0] MOD = ca_pkg::CA_MODE_CTRL_ADDR;
    localparam logic [7:0] CLO = ca_pkg::CA_CNT_LO_ADDR;
    localparam logic [7:0] CHI = ca_pkg::CA_CNT_HI_ADDR;
    logic sys_clk = 1'b0, srst = 1'b1, cpu_idle = 1'b0, clock_6t = 1'b0;
    logic t0_ovf = 1'b0, ext_go = 1'b0, ext_in, hit, irq, wdr;
    logic [4:0] pin_in, pin_out, pin_level = 5'h1f;
    logic [7:0] rdata, pwm_lo [3] = '{8'h90, 8'h7f, 8'h80};
    logic [7:0] exp_cnt [6] = '{8'h08, 8'h18, 8'h0c, 8'h08, 8'h10, 8'h30};
    ca_pkg::ca_sfr_req_t req = '0;
    int fails = 0, comparisons = 0, wdr_cnt = 0;
    ca_counter_array dut_u (.sys_clk(sys_clk), .srst(srst), .sfr_req(req),
        .sfr_rdata(rdata), .sfr_hit(hit), .cpu_idle(cpu_idle),
        .clock_6t(clock_6t), .t0_overflow(t0_ovf), .ext_count_input(ext_in),
        .module_pin_in(pin_in), .module_pin(pin_out), .irq_req(irq),
        .wdog_reset(wdr));
    ca_pin_model pins_u (.sys_clk(sys_clk), .pin_level(pin_level),
        .ext_pulses(8'h08), .ext_go(ext_go), .ext_count_input(ext_in),
        .module_pin_in(pin_in));
    initial begin
        forever #20 sys_clk = ~sys_clk;
    end
    always @(negedge sys_clk) if (wdr === 1'b1) wdr_cnt++;
    task automatic close_out();
        if (fails == 0 && comparisons > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : close_out
    task automatic chk(string nm, logic [15:0] e, logic [15:0] g, bit tol);
        comparisons++;
        if ($isunknown(g) || (tol ? (g > e + 1 || g + 1 < e) : g !== e)) begin
            fails++;
            $display("MISMATCH %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    task automatic wr(logic [7:0] ad, logic [7:0] v);
        @(negedge sys_clk);
        req = '{ad, 1'b1, v};
        @(negedge sys_clk);
        req.wr = 1'b0;
    endtask : wr
    task automatic rd(string nm, logic [7:0] ad, logic [7:0] e, bit tol = 0);
        @(negedge sys_clk);
        req.addr = ad;
        #1;
        chk(nm, 16'(e), 16'(rdata), tol);
    endtask : rd
    task automatic cyc(int n);
        repeat (n) @(negedge sys_clk);
    endtask : cyc
    task automatic wait_hi(bit w);
        int n;
        n = 0;
        while ((w ? wdr : irq) !== 1'b1 && n < 400) begin
            @(negedge sys_clk);
            n++;
        end
        chk("wait", 16'h0000, 16'(n >= 400), 0);
        if (n >= 400) close_out();
    endtask : wait_hi
    initial begin
        cyc(8);
        srst = 1'b0;
        rd("reset_run", RUN, 8'h00);
        rd("unmapped", 8'h00, 8'h00);
        chk("hit_unmapped", 16'h0000, 16'(hit), 0);
        chk("pin_reset", 16'h001f, 16'(pin_out), 0);
        wr(MOD, 8'hff);
        rd("mode_ctrl", MOD, 8'hc7);
        wr(8'hda, 8'hff);
        rd("module_mode", 8'hda, 8'h7f);
        chk("hit_mode", 16'h0001, 16'(hit), 0);
        wr(8'hda, 8'h00);
        for (int i = 0; i < 6; i++) begin
            clock_6t = (i >= 4);
            wr(CLO, 8'h00);
            wr(MOD, {5'h00, 2'(i % 4), 1'b0});
            wr(RUN, 8'h40);
            for (int k = 0; k < 96; k++) begin
                @(negedge sys_clk);
                t0_ovf = (i == 2) && (k % 8 == 0);
                ext_go = (i == 3) && (k == 0);
            end
            wr(RUN, 8'h00);
            rd("count_source", CLO, exp_cnt[i], 1);
        end
        cyc(4);
        clock_6t = 1'b0;
        cpu_idle = 1'b1;
        wr(CLO, 8'h00);
        wr(MOD, 8'h82);
        wr(RUN, 8'h40);
        rd("idle_stop", CLO, 8'h00);
        cyc(40);
        rd("idle_stop", CLO, 8'h00);
        wr(MOD, 8'h02);
        cyc(40);
        rd("idle_run", CLO, 8'h0a, 1);
        cpu_idle = 1'b0;
        wr(RUN, 8'h00);
        wr(CLO, 8'hfe);
        wr(CHI, 8'hff);
        wr(MOD, 8'h03);
        wr(RUN, 8'h40);
        cyc(20);
        rd("overflow", RUN, 8'hc0);
        cyc(2);
        chk("irq_ovf", 16'h0001, 16'(irq), 0);
        rd("wrap_hi", CHI, 8'h00);
        wr(MOD, 8'h02);
        chk("irq_masked", 16'h0000, 16'(irq), 0);
        wr(RUN, 8'h80);
        rd("ovf_sw", RUN, 8'h80);
        wr(CLO, 8'h00);
        wr(CHI, 8'h00);
        wr(8'heb, 8'h10);
        wr(8'hdb, 8'h4d);
        wr(RUN, 8'h40);
        wait_hi(0);
        chk("toggle_pin", 16'h001d, 16'(pin_out), 0);
        rd("match_flag", RUN, 8'h42);
        wr(RUN, 8'h00);
        wr(8'hdb, 8'h00);
        wr(CLO, 8'h34);
        wr(CHI, 8'h12);
        wr(8'hda, 8'h20);
        wr(8'hdc, 8'h10);
        wr(8'hdd, 8'h31);
        pin_level = 5'h12;
        cyc(6);
        rd("fall_cap", RUN, 8'h0c);
        rd("cap_lo", 8'hec, 8'h34);
        rd("cap_hi", 8'hfd, 8'h12);
        wr(CLO, 8'h78);
        pin_level = 5'h1f;
        cyc(6);
        rd("rise_cap", RUN, 8'h0d);
        rd("cap_new", 8'hea, 8'h78);
        chk("irq_cap", 16'h0001, 16'(irq), 0);
        wr(RUN, 8'h00);
        wr(8'hda, 8'h00);
        wr(8'hdd, 8'h00);
        wr(8'hec, 8'h80);
        wr(8'hfc, 8'h40);
        wr(8'hdc, 8'h42);
        foreach (pwm_lo[i]) begin
            wr(CLO, pwm_lo[i]);
            cyc(2);
            chk("pwm_pin", 16'(pwm_lo[i] >= 8'h80), 16'(pin_out[2]), 0);
        end
        wr(CLO, 8'hfe);
        wr(RUN, 8'h40);
        cyc(16);
        wr(RUN, 8'h00);
        rd("pwm_reload", 8'hec, 8'h40);
        wr(8'hdc, 8'h00);
        wr(CLO, 8'h00);
        wr(CHI, 8'h00);
        wr(8'hee, 8'h08);
        wr(8'hfe, 8'h00);
        wr(8'hde, 8'h48);
        wr(RUN, 8'h40);
        cyc(60);
        chk("wdog_off", 16'h0000, 16'(wdr_cnt), 0);
        rd("mod4_flag", RUN, 8'h50);
        wr(RUN, 8'h00);
        wr(CLO, 8'h00);
        wr(MOD, 8'h42);
        wr(RUN, 8'h40);
        wait_hi(1);
        cyc(2);
        chk("wdog_pulse", 16'h0001, 16'(wdr_cnt), 0);
        close_out();
    end
endmodule : ca_counter_array_tb
